// ### pkg/ssr_pkg.sv
// package: register map, field layout and encodings for the scene store/recall block
package ssr_pkg;

  // avalon word addresses (byte offset / 4), word-addressed slave
  localparam logic [3:0] ADDR_CTRL   = 4'h0;  // bit0 scenes enable
  localparam logic [3:0] ADDR_SCENE  = 4'h1;  // write: scene telegram byte (write-only object)
  localparam logic [3:0] ADDR_STATUS = 4'h2;  // read: contact, learned mask, last slot
  localparam logic [3:0] ADDR_SLOT0  = 4'h8;  // slot i config at ADDR_SLOT0 + i

  // slot config word layout
  localparam int SLOT_NUM_LSB   = 0;   // scene number, 6 bits
  localparam int SLOT_ASSIGN_B  = 8;   // 1 = assigned
  localparam int SLOT_LEARN_B   = 9;   // 1 = storing enabled
  localparam int SLOT_DEFPOS_B  = 10;  // default contact position

  // telegram byte layout
  localparam int TEL_LEARN_B    = 7;
  localparam int TEL_NUM_LSB    = 0;

  // status word layout
  localparam int STAT_POS_B     = 0;
  localparam int STAT_LEARNED_LSB = 8;
  localparam int STAT_HIT_LSB   = 16;
  localparam int STAT_HITV_B    = 19;

  localparam int NUM_SLOTS = 8;

  // contact positions: 0 = no open / nc closed, 1 = no closed / nc open
  localparam logic POS_NO_OPEN   = 1'b0;
  localparam logic POS_NO_CLOSED = 1'b1;

  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_EXEC = 3'b010,
    ST_ACK  = 3'b100
  } ssr_state_t;

endpackage

// ### src/ssr_scene_store_recall.sv
// top: scene store/recall handler with avalon-mm register access
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module ssr_scene_store_recall (
  // clock and reset
  input  wire logic        CLOCK,
  input  wire logic        RST,
  // avalon-mm slave
  input  wire logic [3:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic [31:0]      AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  // relay contact and scene done pulse
  output logic             CONTACT_POS,
  output logic             SCENE_DONE
);

  localparam int N = ssr_pkg::NUM_SLOTS;

  typedef struct packed {
    ssr_pkg::ssr_state_t state_reg;
    logic                enable_reg;
    logic [N-1:0][5:0]   num_reg;
    logic [N-1:0]        assign_reg;
    logic [N-1:0]        learn_reg;
    logic [N-1:0]        def_reg;
    logic [7:0]          tel_reg;
    logic                contact_reg;
    logic                done_reg;
    logic [2:0]          hit_idx_reg;
    logic                hit_v_reg;
    logic [31:0]         rdata_reg;
    logic                wait_reg;
  } ssr_state_s_t;

  ssr_state_s_t s_reg;
  ssr_state_s_t s_next;

  ////////////////////////////////////////////////////////////////////////////////
  // slots
  logic [N-1:0] hit;
  logic [N-1:0] recall_pos;
  logic [N-1:0] learned;
  logic [N-1:0] cfg_load;
  logic         learn_stb;

  // bit 6 of the telegram plays no part
  assign learn_stb = (s_reg.state_reg == ssr_pkg::ST_EXEC) && s_reg.enable_reg
                     && s_reg.tel_reg[ssr_pkg::TEL_LEARN_B];

  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_slot
      // eight independent slots
      assign cfg_load[gi] = AVS_WRITE && !s_reg.wait_reg
                            && AVS_ADDRESS == ssr_pkg::ADDR_SLOT0 + 4'(gi);
      ssr_slot u_slot (
        .clk          (CLOCK),
        .rst          (RST),
        .cfg_num      (s_reg.num_reg[gi]),
        .cfg_assigned (s_reg.assign_reg[gi]),
        .cfg_learn_en (s_reg.learn_reg[gi]),
        .cfg_default  (s_reg.def_reg[gi]),
        .cfg_load     (cfg_load[gi]),
        .tel_num      (s_reg.tel_reg[5:0]),
        .learn_stb    (learn_stb),
        .contact_now  (s_reg.contact_reg),
        .hit          (hit[gi]),
        .recall_pos   (recall_pos[gi]),
        .learned      (learned[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // next state
  logic       any_hit;
  logic [2:0] hit_idx;

  always_comb begin
    any_hit = 1'b0;
    hit_idx = 3'd0;
    // numbers are kept distinct by the configurer; lowest slot wins otherwise
    for (int i = N - 1; i >= 0; i--) begin
      if (hit[i]) begin
        any_hit = 1'b1;
        hit_idx = 3'(i);
      end
    end
  end

  always_comb begin
    s_next = s_reg;
    s_next.done_reg = 1'b0;
    s_next.wait_reg = 1'b1;
    unique case (s_reg.state_reg)
      ssr_pkg::ST_IDLE: begin
        if ((AVS_READ || AVS_WRITE) && s_reg.wait_reg) begin
          s_next.state_reg = ssr_pkg::ST_ACK;
          s_next.wait_reg  = 1'b0;
          s_next.rdata_reg = ssr_pkg::RD_ZERO;
          if (AVS_READ) begin
            if (AVS_ADDRESS == ssr_pkg::ADDR_CTRL) begin
              s_next.rdata_reg[0] = s_reg.enable_reg;
            end else if (AVS_ADDRESS == ssr_pkg::ADDR_STATUS) begin
              s_next.rdata_reg[ssr_pkg::STAT_POS_B] = s_reg.contact_reg;
              s_next.rdata_reg[ssr_pkg::STAT_LEARNED_LSB +: N] = learned;
              s_next.rdata_reg[ssr_pkg::STAT_HIT_LSB +: 3] = s_reg.hit_idx_reg;
              s_next.rdata_reg[ssr_pkg::STAT_HITV_B] = s_reg.hit_v_reg;
            end else if (AVS_ADDRESS >= ssr_pkg::ADDR_SLOT0) begin
              s_next.rdata_reg[ssr_pkg::SLOT_NUM_LSB +: 6] =
                s_reg.num_reg[AVS_ADDRESS[2:0]];
              s_next.rdata_reg[ssr_pkg::SLOT_ASSIGN_B] = s_reg.assign_reg[AVS_ADDRESS[2:0]];
              s_next.rdata_reg[ssr_pkg::SLOT_LEARN_B]  = s_reg.learn_reg[AVS_ADDRESS[2:0]];
              s_next.rdata_reg[ssr_pkg::SLOT_DEFPOS_B] = s_reg.def_reg[AVS_ADDRESS[2:0]];
            end
            // scene object is write-only, reads as zero
          end else begin
            if (AVS_ADDRESS == ssr_pkg::ADDR_CTRL && AVS_BYTEENABLE[0]) begin
              s_next.enable_reg = AVS_WRITEDATA[0];
            end else if (AVS_ADDRESS == ssr_pkg::ADDR_SCENE && AVS_BYTEENABLE[0]) begin
              // one byte carries both perform and learn
              s_next.tel_reg   = AVS_WRITEDATA[7:0];
              s_next.state_reg = ssr_pkg::ST_EXEC;
              s_next.wait_reg  = 1'b1;
            end else if (AVS_ADDRESS >= ssr_pkg::ADDR_SLOT0 && AVS_BYTEENABLE[1:0] == 2'b11) begin
              s_next.num_reg[AVS_ADDRESS[2:0]] = AVS_WRITEDATA[ssr_pkg::SLOT_NUM_LSB +: 6];
              s_next.assign_reg[AVS_ADDRESS[2:0]] = AVS_WRITEDATA[ssr_pkg::SLOT_ASSIGN_B];
              s_next.learn_reg[AVS_ADDRESS[2:0]]  = AVS_WRITEDATA[ssr_pkg::SLOT_LEARN_B];
              // one bit: only the two documented positions exist
              s_next.def_reg[AVS_ADDRESS[2:0]]    = AVS_WRITEDATA[ssr_pkg::SLOT_DEFPOS_B];
            end
          end
        end
      end
      ssr_pkg::ST_EXEC: begin
        // telegram acted on one cycle after capture, and the bus is released in that same cycle
        s_next.state_reg = ssr_pkg::ST_ACK;
        s_next.wait_reg  = 1'b0;
        if (s_reg.enable_reg && any_hit) begin
          s_next.hit_idx_reg = hit_idx;
          s_next.hit_v_reg   = 1'b1;
          s_next.done_reg    = 1'b1;
          if (!s_reg.tel_reg[ssr_pkg::TEL_LEARN_B]) begin
            s_next.contact_reg = recall_pos[hit_idx];
          end
        end
      end
      ssr_pkg::ST_ACK: begin
        s_next.state_reg = ssr_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      s_reg             <= '0;
      s_reg.state_reg   <= ssr_pkg::ST_IDLE;
      s_reg.wait_reg    <= 1'b1;
      s_reg.contact_reg <= ssr_pkg::POS_NO_OPEN;
    end else begin
      s_reg <= s_next;
    end
  end

  assign AVS_READDATA    = s_reg.rdata_reg;
  assign AVS_WAITREQUEST = s_reg.wait_reg;
  assign CONTACT_POS     = s_reg.contact_reg;
  assign SCENE_DONE      = s_reg.done_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  perform_drive_a: assert property (@(posedge CLOCK) disable iff (RST)
    (s_reg.state_reg == ssr_pkg::ST_EXEC && s_reg.enable_reg && any_hit
     && !s_reg.tel_reg[7]) |=> (CONTACT_POS == $past(recall_pos[hit_idx])))
    else $error("perform did not drive stored position");

  disabled_quiet_a: assert property (@(posedge CLOCK) disable iff (RST)
    (s_reg.state_reg == ssr_pkg::ST_EXEC && !s_reg.enable_reg) |=> $stable(CONTACT_POS) && !SCENE_DONE)
    else $error("scene acted while disabled");

  learn_hold_a: assert property (@(posedge CLOCK) disable iff (RST)
    (s_reg.state_reg == ssr_pkg::ST_EXEC && s_reg.tel_reg[7]) |=> $stable(CONTACT_POS))
    else $error("learn moved the contact");

  no_match_a: assert property (@(posedge CLOCK) disable iff (RST)
    (s_reg.state_reg == ssr_pkg::ST_EXEC && !any_hit) |=> !SCENE_DONE && $stable(CONTACT_POS))
    else $error("unmatched telegram acted");

  default_recall_a: assert property (@(posedge CLOCK) disable iff (RST)
    (s_reg.state_reg == ssr_pkg::ST_EXEC && s_reg.enable_reg && any_hit && !s_reg.tel_reg[7]
     && !s_reg.learn_reg[hit_idx]) |=> (CONTACT_POS == $past(s_reg.def_reg[hit_idx])))
    else $error("locked slot did not give default");

  bus_answer_a: assert property (@(posedge CLOCK) disable iff (RST)
    ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST && s_reg.state_reg == ssr_pkg::ST_IDLE)
    |-> ##[1:2] !AVS_WAITREQUEST)
    else $error("bus request not answered in time");

  wait_pulse_a: assert property (@(posedge CLOCK) disable iff (RST)
    !AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("waitrequest low longer than one cycle");

  done_pulse_a: assert property (@(posedge CLOCK) disable iff (RST)
    SCENE_DONE |=> !SCENE_DONE)
    else $error("done longer than one cycle");

  perform_c: cover property (@(posedge CLOCK) disable iff (RST)
    SCENE_DONE && !s_reg.tel_reg[7]);
  learn_c: cover property (@(posedge CLOCK) disable iff (RST)
    SCENE_DONE && s_reg.tel_reg[7]);
  contact_flip_c: cover property (@(posedge CLOCK) disable iff (RST)
    $changed(CONTACT_POS));

endmodule

// ### src/ssr_slot.sv
// one scene slot: configuration match and stored contact position
`timescale 1ns/1ps
module ssr_slot (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // configuration
  input  wire logic [5:0] cfg_num,
  input  wire logic       cfg_assigned,
  input  wire logic       cfg_learn_en,
  input  wire logic       cfg_default,
  input  wire logic       cfg_load,
  // telegram
  input  wire logic [5:0] tel_num,
  input  wire logic       learn_stb,
  input  wire logic       contact_now,
  // results
  output logic            hit,
  output logic            recall_pos,
  output logic            learned
);

  typedef struct packed {
    logic pos_reg;
    logic learned_reg;
  } ssr_slot_state_t;

  ssr_slot_state_t s_reg;
  ssr_slot_state_t s_next;

  // unassigned slot never matches
  assign hit = cfg_assigned && (cfg_num == tel_num);

  // storing disabled recalls the default, else learned or default content
  assign recall_pos = cfg_learn_en ? s_reg.pos_reg : cfg_default;
  assign learned = s_reg.learned_reg;

  always_comb begin
    s_next = s_reg;
    if (cfg_load) begin
      // default serves as content until the first learn
      s_next.pos_reg     = cfg_default;
      s_next.learned_reg = 1'b0;
    end else if (learn_stb && hit && cfg_learn_en) begin
      s_next.pos_reg     = contact_now;
      s_next.learned_reg = 1'b1;
    end
    // learn with storing disabled leaves the content alone
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  stored_learn_a: assert property (@(posedge clk) disable iff (rst)
    (learn_stb && hit && cfg_learn_en && !cfg_load) |=> (s_reg.pos_reg == $past(contact_now)))
    else $error("slot did not store contact position");

  locked_slot_a: assert property (@(posedge clk) disable iff (rst)
    (!cfg_learn_en && !cfg_load) |=> $stable(s_reg.pos_reg))
    else $error("slot changed with storing disabled");

endmodule

// ### tb/ssr_sender.sv
// partner model: bus sender issuing scene telegrams and config accesses
`timescale 1ns/1ps
module ssr_sender (
  // clock
  input  wire logic        clk,
  // avalon-mm master side
  output logic [3:0]       avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic [31:0]      avs_writedata,
  output logic [3:0]       avs_byteenable,
  input  wire logic        avs_waitrequest,
  // hang flag
  output logic             hang
);
  initial begin
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'h0;
    hang = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // one transfer; random idle gap models a slow sender
  task automatic xfer(input logic rd, input logic [3:0] a, input logic [31:0] d,
                      input logic [3:0] be);
    int n;
    n = 0;
    repeat ($urandom % 3) @(posedge clk);
    @(posedge clk);
    avs_address <= a;
    avs_read <= rd;
    avs_write <= !rd;
    avs_writedata <= d;
    avs_byteenable <= be;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest && n < 50);
    if (n >= 50) hang <= 1'b1;
    // released bus shows inverted garbage, not the last value
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_address <= ~a;
    avs_writedata <= ~d;
  endtask

  // perform and learn both go through the one-byte scene object
  task automatic scene(input logic [7:0] b);
    xfer(1'b0, ssr_pkg::ADDR_SCENE, {24'h00_0000, b}, 4'b0001);
  endtask
endmodule

// ### tb/tb_top.sv
// testbench: scene store/recall block driven by the sender model
`timescale 1ns/1ps
module tb_top;
  logic        CLOCK;
  logic        RST;
  logic [3:0]  AVS_ADDRESS;
  logic        AVS_READ;
  logic        AVS_WRITE;
  logic [31:0] AVS_WRITEDATA;
  logic [3:0]  AVS_BYTEENABLE;
  logic [31:0] AVS_READDATA;
  logic        AVS_WAITREQUEST;
  logic        CONTACT_POS;
  logic        SCENE_DONE;
  logic        hang;
  logic        pos;
  logic [5:0]  base;
  logic [31:0] exp_rd[$];
  logic        exp_pos[$];
  int          mismatches;
  int          checked;

  ssr_scene_store_recall u_ssr_scene_store_recall (
    .CLOCK(CLOCK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .CONTACT_POS(CONTACT_POS), .SCENE_DONE(SCENE_DONE));

  ssr_sender u_ssr_sender (
    .clk(CLOCK), .avs_address(AVS_ADDRESS), .avs_read(AVS_READ), .avs_write(AVS_WRITE),
    .avs_writedata(AVS_WRITEDATA), .avs_byteenable(AVS_BYTEENABLE),
    .avs_waitrequest(AVS_WAITREQUEST), .hang(hang));

  initial begin
    CLOCK = 1'b0;
    forever #50 CLOCK = ~CLOCK;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected read at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_pos(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected contact at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    exp_rd.push_back(e);
    u_ssr_sender.xfer(1'b1, a, 32'h0000_0000, 4'b1111);
  endtask

  // s is a slot index; 8 gives a number no slot holds; bit 6 is random
  task automatic scene(input logic lrn, input int s, input logic hit);
    if (hit) exp_pos.push_back(pos);
    u_ssr_sender.scene({lrn, 1'($urandom), base + 6'(s)});
  endtask

  task automatic cfg(input int s, input logic asg);
    u_ssr_sender.xfer(1'b0, 4'(ssr_pkg::ADDR_SLOT0 + s),
                      {21'h0, 1'(s >> 1), 1'(s), asg, 2'b00, base + 6'(s)}, 4'b1111);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // monitor: each answer takes the oldest note
  always @(posedge CLOCK) begin
    if (hang) begin
      mismatches++;
      end_of_test();
    end
    if (!RST && AVS_READ && AVS_WAITREQUEST === 1'b0) begin
      if (exp_rd.size() > 0) cmp_rd(AVS_READDATA, exp_rd.pop_front());
      else mismatches++;
    end
    if (!RST && SCENE_DONE === 1'b1) begin
      if (exp_pos.size() > 0) cmp_pos(CONTACT_POS, exp_pos.pop_front());
      else mismatches++;
    end
  end

  initial begin
    RST = 1'b1;
    pos = 1'b0;
    void'($urandom(58));
    base = 6'($urandom % 56);
    repeat (3) @(posedge CLOCK);
    RST <= 1'b0;
    // slot i: storing = i[0], default = i[1], numbers kept distinct
    for (int i = 0; i < 8; i++) cfg(i, 1'b1);
    scene(1'b0, 2, 1'b0);
    rd(ssr_pkg::ADDR_STATUS, 32'h0000_0000);
    u_ssr_sender.xfer(1'b0, ssr_pkg::ADDR_CTRL, 32'h0000_0001, 4'b0001);
    for (int s = 0; s < 8; s++) begin
      pos = 1'(s >> 1);
      scene(1'b0, s, 1'b1);
    end
    scene(1'b1, 5, 1'b1);
    // learn on a locked slot still matches but must leave contact and content alone
    scene(1'b1, 0, 1'b1);
    pos = 1'b0;
    scene(1'b0, 1, 1'b1);
    pos = 1'b1;
    scene(1'b0, 5, 1'b1);
    pos = 1'b0;
    scene(1'b0, 0, 1'b1);
    scene(1'b0, 8, 1'b0);
    cfg(4, 1'b0);
    scene(1'b0, 4, 1'b0);
    rd(ssr_pkg::ADDR_STATUS, 32'h0008_2000);
    rd(ssr_pkg::ADDR_SCENE, 32'h0000_0000);
    rd(4'h5, 32'h0000_0000);
    repeat (3) @(posedge CLOCK);
    mismatches += exp_rd.size() + exp_pos.size();
    end_of_test();
  end
endmodule
